/* ssfc_pkg.sv */
package ssfc_pkg;
  // ==========================================
  // Widths and bus answers
  localparam int DW = 16;
  localparam int AW = 8;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ==========================================
  // Register map (byte offsets)
  localparam logic [7:0] OFF_COUNT = 8'h00;
  localparam logic [7:0] OFF_TYPE = 8'h04;
  localparam logic [7:0] OFF_PARAM0 = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h38;
  localparam int NPARAM = 12;

  // ==========================================
  // Filter count and type word
  localparam logic [1:0] COUNT_RST = 2'h0;
  localparam logic [1:0] COUNT_MAX = 2'h2;
  localparam logic [15:0] TYPE_RST = 16'h0000;
  localparam logic [15:0] TYPE_MASK = 16'h8303;
  localparam int TB_S1_NOTCH = 0;
  localparam int TB_S2_NOTCH = 1;
  localparam int TB_S1_PT1 = 8;
  localparam int TB_S2_PT1 = 9;
  localparam int TB_ZTRANS = 15;

  // ==========================================
  // Coefficient settings, index order:
  // s1 tc, s2 tc, s1 nf, s1 damp, s2 nf, s2 damp,
  // s1 block, s1 bw, s1 num bw, s2 block, s2 bw, s2 num bw
  // Units: tc 0.1 ms, freq Hz, damping 0.01
  localparam int P_S1_TC = 0;
  localparam int P_S2_TC = 1;
  localparam int P_S1_NF = 2;
  localparam int P_S1_DAMP = 3;
  localparam int P_S2_NF = 4;
  localparam int P_S2_DAMP = 5;
  localparam int P_S1_BF = 6;
  localparam int P_S1_BW = 7;
  localparam int P_S1_NBW = 8;
  localparam int P_S2_BF = 9;
  localparam int P_S2_BW = 10;
  localparam int P_S2_NBW = 11;
  localparam logic [15:0] PMIN [NPARAM] = '{16'h0000, 16'h0000, 16'h000a, 16'h0014,
    16'h000a, 16'h0014, 16'h0001, 16'h0005, 16'h0000, 16'h0001, 16'h0005, 16'h0000};
  localparam logic [15:0] PMAX [NPARAM] = '{16'h1388, 16'h1388, 16'h1f40, 16'h01f4,
    16'h1f40, 16'h01f4, 16'h1f3f, 16'h1f3f, 16'h1f3f, 16'h1f3f, 16'h1f3f, 16'h1f3f};
  localparam logic [15:0] PDEF [NPARAM] = '{16'h0000, 16'h0000, 16'h07d0, 16'h0046,
    16'h07d0, 16'h0046, 16'h0dac, 16'h01f4, 16'h0000, 16'h0dac, 16'h01f4, 16'h0000};

  // ==========================================
  // Arithmetic scales
  localparam int Q = 16;
  localparam int XSH = 8;
  localparam longint TWO_PI_Q16 = 64'd411775;
  localparam longint DAMP_SCALE = 64'd100;
  localparam longint TC_SCALE = 64'd10000;
  localparam longint ONE_Q16 = 64'd65536;
  localparam longint CUBE_DIV = 64'd24;

  typedef enum logic [1:0] {
    SSFC_PASS = 2'b00,
    SSFC_PT1 = 2'b01,
    SSFC_PT2 = 2'b10,
    SSFC_NOTCH = 2'b11
  } ssfc_mode_t;

  typedef struct packed {
    ssfc_mode_t mode;
    logic ztrans;
    logic [15:0] tc;
    logic [15:0] nf;
    logic [15:0] damp;
    logic [15:0] bf;
    logic [15:0] bw;
    logic [15:0] nbw;
  } ssfc_cfg_t;
endpackage

/* ssfc_fifo.sv */
`timescale 1ns/1ps
module ssfc_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [PW:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != (PW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  assign level = cnt_r;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

/* ssfc_stage.sv */
`timescale 1ns/1ps
module ssfc_stage #(
  parameter longint FS = 16000
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Live configuration
  input wire ssfc_pkg::ssfc_cfg_t cfg,
  // Sample in
  input wire logic in_valid,
  output logic in_ready,
  input wire logic signed [ssfc_pkg::DW-1:0] in_data,
  // Sample out
  output logic out_valid,
  input wire logic out_ready,
  output logic signed [ssfc_pkg::DW-1:0] out_data
);
  // State variable form: one structure serves PT2 and band-stop
  logic signed [39:0] lo_r;
  logic signed [39:0] bd_r;
  logic ov_r;
  logic signed [63:0] x;
  logic signed [63:0] w;
  logic signed [63:0] q;
  logic signed [63:0] qn;
  logic signed [63:0] a;
  logic signed [63:0] hp;
  logic signed [63:0] bdn;
  logic signed [63:0] lon;
  logic signed [63:0] y;
  logic signed [63:0] f;
  logic take;

  assign in_ready = !ov_r || out_ready;
  assign take = in_valid && in_ready;
  assign out_valid = ov_r;

  always_comb begin
    x = 64'(in_data) <<< ssfc_pkg::XSH;
    f = (cfg.mode == ssfc_pkg::SSFC_NOTCH) ? 64'(cfg.bf) : 64'(cfg.nf);
    w = (f * ssfc_pkg::TWO_PI_Q16) / FS;
    // Bilinear form uses the sine-warped gain, Z form the plain one
    if (cfg.mode == ssfc_pkg::SSFC_NOTCH && !cfg.ztrans) begin
      w = w - ((((w * w) >>> ssfc_pkg::Q) * w) >>> ssfc_pkg::Q) / ssfc_pkg::CUBE_DIV;
    end
    q = (64'(cfg.damp) * 2 * ssfc_pkg::ONE_Q16) / ssfc_pkg::DAMP_SCALE;
    qn = 64'sd0;
    if (cfg.mode == ssfc_pkg::SSFC_NOTCH) begin
      q = (64'(cfg.bw) <<< ssfc_pkg::Q) / 64'(cfg.bf);
      qn = (64'(cfg.nbw) <<< ssfc_pkg::Q) / 64'(cfg.bf);
    end
    a = (ssfc_pkg::ONE_Q16 * ssfc_pkg::TC_SCALE) / (64'(cfg.tc) * FS + ssfc_pkg::TC_SCALE);
    hp = x - 64'(lo_r) - ((q * 64'(bd_r)) >>> ssfc_pkg::Q);
    bdn = 64'(bd_r) + ((w * hp) >>> ssfc_pkg::Q);
    lon = 64'(lo_r) + ((w * bdn) >>> ssfc_pkg::Q);
    unique case (cfg.mode)
      ssfc_pkg::SSFC_PASS: begin
        lon = x;
        bdn = 64'sd0;
      end
      ssfc_pkg::SSFC_PT1: begin
        lon = 64'(lo_r) + ((a * (x - 64'(lo_r))) >>> ssfc_pkg::Q);
        bdn = 64'sd0;
      end
      ssfc_pkg::SSFC_PT2: begin
      end
      ssfc_pkg::SSFC_NOTCH: begin
      end
    endcase
    if (cfg.mode == ssfc_pkg::SSFC_NOTCH) begin
      y = x - (((q - qn) * bdn) >>> ssfc_pkg::Q);
    end else begin
      y = lon;
    end
    y = y >>> ssfc_pkg::XSH;
    if (y > 64'sd32767) begin
      y = 64'sd32767;
    end else if (y < -64'sd32768) begin
      y = -64'sd32768;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lo_r <= '0;
      bd_r <= '0;
      ov_r <= 1'b0;
      out_data <= '0;
    end else begin
      if (take) begin
        lo_r <= 40'(lon);
        bd_r <= 40'(bdn);
        out_data <= 16'(y);
        ov_r <= 1'b1;
      end else if (out_ready) begin
        ov_r <= 1'b0;
      end
    end
  end
endmodule

/* ssfc_top.sv */
// Summary of operation
// (R1) Filter count 0 runs no stage, 1 runs stage one, 2 runs both; larger writes are refused.
// (R2) Type bit 0 makes stage one a band-stop, else a low pass.
// (R3) Type bit 1 makes stage two a band-stop, else a low pass.
// (R4) For a low-pass stage one, type bit 8 picks PT1 when set and PT2 when clear.
// (R5) For a low-pass stage two, type bit 9 picks PT1 when set and PT2 when clear.
// (R6) Type bit 15 picks Z transformation for band-stops when set, bilinear when clear.
// (R7) The bypass input switches stage one out only while it is a low pass.
// (R8) The type word is 16 bits, resets to zero and holds no bits outside 8303 hex.
// (R9) Software loads a stage's coefficients before changing that stage's type.
// (R10) Each stage has its own PT1 time constant, 0 to 500 ms, default 0.
// (R11) PT2 natural frequency is 10 to 8000 Hz (default 2000), damping 0.2 to 5.0 (0.7).
// (R12) Band-stop blocking frequency is 1 to 7999 Hz (3500), bandwidth 5 to 7999 Hz (500).
// (R13) Band-stop numerator bandwidth is 0 to 7999 Hz, default 0, per stage.
// (R14) Every setting acts on the next sample after the write, with no restart.
// (R15) Samples pass stage one then stage two; idle stages pass samples unchanged.
`timescale 1ns/1ps
module ssfc_top #(
  parameter longint FS = 16000,
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ssfc_pkg::AW-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ssfc_pkg::AW-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Setpoint from the source
  input wire logic sp_in_valid,
  output logic sp_in_ready,
  input wire logic signed [ssfc_pkg::DW-1:0] sp_in_data,
  // Setpoint to the speed controller
  output logic sp_out_valid,
  input wire logic sp_out_ready,
  output logic signed [ssfc_pkg::DW-1:0] sp_out_data,
  // First filter off request
  input wire logic stage1_bypass
);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  // ==========================================
  // Helpers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = nw[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = nw[15:8];
    end
  endfunction

  function automatic logic is_param(input logic [ssfc_pkg::AW-1:0] addr);
    is_param = addr[1:0] == 2'b00 && addr >= ssfc_pkg::OFF_PARAM0 &&
               addr < ssfc_pkg::OFF_STATUS;
  endfunction

  function automatic int param_idx(input logic [ssfc_pkg::AW-1:0] addr);
    param_idx = int'((addr - ssfc_pkg::OFF_PARAM0) >> 2);
  endfunction

  function automatic ssfc_pkg::ssfc_mode_t stage_mode(input logic enabled, input logic notch,
                                                      input logic pt1, input logic bypass);
    if (!enabled || (bypass && !notch)) begin
      stage_mode = ssfc_pkg::SSFC_PASS;
    end else if (notch) begin
      stage_mode = ssfc_pkg::SSFC_NOTCH;
    end else if (pt1) begin
      stage_mode = ssfc_pkg::SSFC_PT1;
    end else begin
      stage_mode = ssfc_pkg::SSFC_PT2;
    end
  endfunction

  // ==========================================
  // Register file
  logic [1:0] count_r;
  logic [15:0] type_r;
  logic [15:0] param_r [ssfc_pkg::NPARAM];
  logic [ssfc_pkg::AW-1:0] awaddr_r;
  logic aw_got_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_got_r;
  logic wr_do;
  logic [15:0] wr_val;
  logic [15:0] type_nxt;
  logic [LW-1:0] fifo_level;
  ssfc_pkg::ssfc_cfg_t cfg1;
  ssfc_pkg::ssfc_cfg_t cfg2;

  assign awready = !aw_got_r && !bvalid;
  assign wready = !w_got_r && !bvalid;
  assign arready = !rvalid;
  assign wr_do = aw_got_r && w_got_r;

  // Address and data may come in either order; each is parked until its mate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= awaddr;
      end else if (wr_do) begin
        aw_got_r <= 1'b0;
      end
      if (wvalid && wready) begin
        w_got_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end else if (wr_do) begin
        w_got_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= ssfc_pkg::RESP_OKAY;
    end else if (wr_do) begin
      bvalid <= 1'b1;
      bresp <= (awaddr_r == ssfc_pkg::OFF_COUNT || awaddr_r == ssfc_pkg::OFF_TYPE ||
                is_param(awaddr_r)) ? ssfc_pkg::RESP_OKAY : ssfc_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_comb begin
    wr_val = 16'h0000;
    if (is_param(awaddr_r)) begin
      wr_val = merge16(param_r[param_idx(awaddr_r)], wdata_r, wstrb_r);
    end
    type_nxt = merge16(type_r, wdata_r, wstrb_r) & ssfc_pkg::TYPE_MASK;
  end

  // (R1) refuse counts above two
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= ssfc_pkg::COUNT_RST;
    end else if (wr_do && awaddr_r == ssfc_pkg::OFF_COUNT && wstrb_r[0] &&
                 wdata_r[15:0] <= 16'(ssfc_pkg::COUNT_MAX)) begin
      count_r <= wdata_r[1:0];
    end
  end

  // (R8) undefined type bits stay zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      type_r <= ssfc_pkg::TYPE_RST;
    end else if (wr_do && awaddr_r == ssfc_pkg::OFF_TYPE) begin
      type_r <= type_nxt;
    end
  end

  // (R10) (R11) (R12) (R13) writes clamp into range
  for (genvar i = 0; i < ssfc_pkg::NPARAM; i++) begin : g_param
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        param_r[i] <= ssfc_pkg::PDEF[i];
      end else if (wr_do && is_param(awaddr_r) && param_idx(awaddr_r) == i) begin
        if (wr_val < ssfc_pkg::PMIN[i]) begin
          param_r[i] <= ssfc_pkg::PMIN[i];
        end else if (wr_val > ssfc_pkg::PMAX[i]) begin
          param_r[i] <= ssfc_pkg::PMAX[i];
        end else begin
          param_r[i] <= wr_val;
        end
      end
    end
  end

  // Reads stall only while an answer waits for rready; unmapped words answer zero with an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= ssfc_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= ssfc_pkg::RESP_OKAY;
      rdata <= '0;
      if (araddr == ssfc_pkg::OFF_COUNT) begin
        rdata <= 32'(count_r);
      end else if (araddr == ssfc_pkg::OFF_TYPE) begin
        rdata <= 32'(type_r);
      end else if (is_param(araddr)) begin
        rdata <= 32'(param_r[param_idx(araddr)]);
      end else if (araddr == ssfc_pkg::OFF_STATUS) begin
        rdata <= {19'h00000, LW'(fifo_level), 4'h0, cfg2.mode, cfg1.mode};
      end else begin
        rresp <= ssfc_pkg::RESP_SLVERR;
      end
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ==========================================
  // Stage configuration, live from the registers
  always_comb begin
    // (R1) (R2) (R4) (R7) (R14) stage one selection
    cfg1.mode = stage_mode(count_r != 2'h0, type_r[ssfc_pkg::TB_S1_NOTCH],
                           type_r[ssfc_pkg::TB_S1_PT1], stage1_bypass);
    // (R6) shared transformation choice
    cfg1.ztrans = type_r[ssfc_pkg::TB_ZTRANS];
    cfg1.tc = param_r[ssfc_pkg::P_S1_TC];
    cfg1.nf = param_r[ssfc_pkg::P_S1_NF];
    cfg1.damp = param_r[ssfc_pkg::P_S1_DAMP];
    cfg1.bf = param_r[ssfc_pkg::P_S1_BF];
    cfg1.bw = param_r[ssfc_pkg::P_S1_BW];
    cfg1.nbw = param_r[ssfc_pkg::P_S1_NBW];
    // (R1) (R3) (R5) stage two selection
    cfg2.mode = stage_mode(count_r == ssfc_pkg::COUNT_MAX, type_r[ssfc_pkg::TB_S2_NOTCH],
                           type_r[ssfc_pkg::TB_S2_PT1], 1'b0);
    cfg2.ztrans = type_r[ssfc_pkg::TB_ZTRANS];
    cfg2.tc = param_r[ssfc_pkg::P_S2_TC];
    cfg2.nf = param_r[ssfc_pkg::P_S2_NF];
    cfg2.damp = param_r[ssfc_pkg::P_S2_DAMP];
    cfg2.bf = param_r[ssfc_pkg::P_S2_BF];
    cfg2.bw = param_r[ssfc_pkg::P_S2_BW];
    cfg2.nbw = param_r[ssfc_pkg::P_S2_NBW];
  end

  // ==========================================
  // Sample path
  logic s1_valid;
  logic s1_ready;
  logic signed [ssfc_pkg::DW-1:0] s1_data;
  logic s2_valid;
  logic s2_ready;
  logic signed [ssfc_pkg::DW-1:0] s2_data;

  // (R15) stage one feeds stage two
  ssfc_stage #(.FS(FS)) u_stage1 (
    .aclk(aclk), .aresetn(aresetn), .cfg(cfg1),
    .in_valid(sp_in_valid), .in_ready(sp_in_ready), .in_data(sp_in_data),
    .out_valid(s1_valid), .out_ready(s1_ready), .out_data(s1_data)
  );

  ssfc_stage #(.FS(FS)) u_stage2 (
    .aclk(aclk), .aresetn(aresetn), .cfg(cfg2),
    .in_valid(s1_valid), .in_ready(s1_ready), .in_data(s1_data),
    .out_valid(s2_valid), .out_ready(s2_ready), .out_data(s2_data)
  );

  // Back-pressure from the controller reaches the source through both stages
  ssfc_fifo #(.W(ssfc_pkg::DW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .aclk(aclk), .aresetn(aresetn),
    .in_valid(s2_valid), .in_ready(s2_ready), .in_data(s2_data),
    .out_valid(sp_out_valid), .out_ready(sp_out_ready), .out_data(sp_out_data),
    .level(fifo_level)
  );

  // ==========================================
  // Checks
  property p_count_legal;
    @(posedge aclk) disable iff (!aresetn) count_r <= ssfc_pkg::COUNT_MAX;
  endproperty
  a_count_legal: assert property (p_count_legal) else $error("filter count above two"); // (R1)

  property p_count_off;
    @(posedge aclk) disable iff (!aresetn)
      count_r == 2'h0 |-> cfg1.mode == ssfc_pkg::SSFC_PASS && cfg2.mode == ssfc_pkg::SSFC_PASS;
  endproperty
  a_count_off: assert property (p_count_off) else $error("stage active at count zero"); // (R1)

  property p_s1_notch;
    @(posedge aclk) disable iff (!aresetn)
      count_r != 2'h0 && type_r[0] |-> cfg1.mode == ssfc_pkg::SSFC_NOTCH;
  endproperty
  a_s1_notch: assert property (p_s1_notch) else $error("stage one band-stop lost"); // (R2)

  property p_s2_notch;
    @(posedge aclk) disable iff (!aresetn)
      count_r == 2'h2 && type_r[1] |-> cfg2.mode == ssfc_pkg::SSFC_NOTCH;
  endproperty
  a_s2_notch: assert property (p_s2_notch) else $error("stage two band-stop lost"); // (R3)

  property p_s1_pt1;
    @(posedge aclk) disable iff (!aresetn)
      count_r != 2'h0 && !type_r[0] && !stage1_bypass |->
        cfg1.mode == (type_r[8] ? ssfc_pkg::SSFC_PT1 : ssfc_pkg::SSFC_PT2);
  endproperty
  a_s1_pt1: assert property (p_s1_pt1) else $error("stage one low-pass order wrong"); // (R4)

  property p_s2_pt1;
    @(posedge aclk) disable iff (!aresetn)
      count_r == 2'h2 && !type_r[1] |->
        cfg2.mode == (type_r[9] ? ssfc_pkg::SSFC_PT1 : ssfc_pkg::SSFC_PT2);
  endproperty
  a_s2_pt1: assert property (p_s2_pt1) else $error("stage two low-pass order wrong"); // (R5)

  property p_bypass;
    @(posedge aclk) disable iff (!aresetn)
      stage1_bypass && count_r != 2'h0 |->
        (cfg1.mode == ssfc_pkg::SSFC_PASS) == !type_r[0];
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass misapplied"); // (R7)

  property p_type_write;
    @(posedge aclk) disable iff (!aresetn)
      wr_do && awaddr_r == ssfc_pkg::OFF_TYPE |=> type_r == $past(type_nxt) && bvalid;
  endproperty
  a_type_write: assert property (p_type_write) else $error("type write not immediate"); // (R14)

  property p_mask;
    @(posedge aclk) disable iff (!aresetn) (type_r & ~ssfc_pkg::TYPE_MASK) == 16'h0000;
  endproperty
  a_mask: assert property (p_mask) else $error("reserved type bit set"); // (R8)

  c_notch_z: cover property (@(posedge aclk) disable iff (!aresetn)
    cfg1.mode == ssfc_pkg::SSFC_NOTCH && cfg1.ztrans && sp_in_valid && sp_in_ready);
  c_two_stages: cover property (@(posedge aclk) disable iff (!aresetn)
    cfg1.mode == ssfc_pkg::SSFC_PT1 && cfg2.mode == ssfc_pkg::SSFC_PT2 && s2_valid);
  c_fifo_full: cover property (@(posedge aclk) disable iff (!aresetn) !s2_ready);
endmodule

/* ssfc_partner.sv */
`timescale 1ns/1ps
// =====
// Setpoint source and speed controller model
module ssfc_partner (
  // Bench control
  input wire logic aclk,
  input wire logic send_go,
  input wire logic [7:0] send_n,
  input wire logic stall,
  // Source side
  output logic sp_in_valid,
  input wire logic sp_in_ready,
  output logic signed [ssfc_pkg::DW-1:0] sp_in_data,
  // Controller side
  input wire logic sp_out_valid,
  output logic sp_out_ready,
  input wire logic signed [ssfc_pkg::DW-1:0] sp_out_data
);
  logic [7:0] left_r;
  logic [7:0] seq_r;
  logic [15:0] rx_q[$];
  initial begin
    sp_in_valid = 1'b0;
    sp_in_data = 16'h0000;
    sp_out_ready = 1'b0;
    left_r = 8'h00;
    seq_r = 8'h00;
  end
  // Idle data toggles so a stale word never passes for a sample
  always @(posedge aclk) begin
    if (send_go) begin
      left_r <= send_n;
      seq_r <= 8'h00;
    end else if (!sp_in_valid || sp_in_ready) begin
      if (left_r != 8'h00) begin
        sp_in_valid <= 1'b1;
        sp_in_data <= {seq_r, seq_r ^ 8'ha5};
        seq_r <= seq_r + 8'h01;
        left_r <= left_r - 8'h01;
      end else begin
        sp_in_valid <= 1'b0;
        sp_in_data <= ~sp_in_data;
      end
    end
  end
  always @(posedge aclk) begin
    sp_out_ready <= !stall;
    if (sp_out_valid && sp_out_ready) rx_q.push_back(sp_out_data);
  end
endmodule

/* test_ssfc_top.sv */
`timescale 1ns/1ps
module test_ssfc_top;
  // Count, type, bypass, expected stage modes
  localparam logic [27:0] MODES [9] = '{28'h200000a, 28'h2010009, 28'h2020006,
    28'h200010b, 28'h280020e, 28'h1000303, 28'h0000300, 28'h2010018, 28'h200011b};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sp_in_ready, sp_out_valid;
  logic [1:0] bresp, rresp;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, send_n = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic stage1_bypass = 1'b0, send_go = 1'b0, stall = 1'b0, sp_in_valid, sp_out_ready;
  logic signed [15:0] sp_in_data, sp_out_data;
  int bad_count = 0;
  int total_checks = 0;
  always #2.5 aclk = ~aclk;
  ssfc_top DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .sp_in_valid(sp_in_valid), .sp_in_ready(sp_in_ready),
    .sp_in_data(sp_in_data), .sp_out_valid(sp_out_valid), .sp_out_ready(sp_out_ready),
    .sp_out_data(sp_out_data), .stage1_bypass(stage1_bypass));
  ssfc_partner src_sink (.aclk(aclk), .send_go(send_go), .send_n(send_n), .stall(stall),
    .sp_in_valid(sp_in_valid), .sp_in_ready(sp_in_ready), .sp_in_data(sp_in_data),
    .sp_out_valid(sp_out_valid), .sp_out_ready(sp_out_ready), .sp_out_data(sp_out_data));
  // =====
  // Checking and bus tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic hang(input string what);
    bad_count++;
    $display("mismatch %s expected answer seen none", what);
    close_out();
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
    bit done;
    done = 1'b0;
    r = 2'b11;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {16'h0000, d};
    wstrb <= 4'hf;
    bready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        done = 1'b1;
        r = bresp;
        bready <= 1'b0;
      end
    end
    if (!done) hang("write");
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit done;
    done = 1'b0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        done = 1'b1;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
    if (!done) hang("read");
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(what, exp, d);
    chk("read resp", 32'(ssfc_pkg::RESP_OKAY), 32'(r));
  endtask
  task automatic send(input logic [7:0] n);
    @(posedge aclk);
    send_n <= n;
    send_go <= 1'b1;
    @(posedge aclk);
    send_go <= 1'b0;
  endtask
  task automatic drain(input int cnt);
    int n;
    n = 0;
    while (src_sink.rx_q.size() < cnt && n < 300) begin
      @(posedge aclk);
      n++;
    end
    if (n == 300) hang("sink");
    chk("sample count", 32'(cnt), 32'(src_sink.rx_q.size()));
    for (int k = 0; k < cnt; k++) begin
      chk("sample", {16'h0, 8'(k), 8'(k) ^ 8'ha5}, 32'(src_sink.rx_q[k]));
    end
    src_sink.rx_q.delete();
  endtask
  // =====
  // Scenarios
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] a;
    rd_chk(ssfc_pkg::OFF_COUNT, 32'h0, "count reset");
    rd_chk(ssfc_pkg::OFF_TYPE, 32'h0, "type reset");
    for (int i = 0; i < ssfc_pkg::NPARAM; i++) begin
      a = 8'(ssfc_pkg::OFF_PARAM0 + 4 * i);
      rd_chk(a, 32'(ssfc_pkg::PDEF[i]), "default");
    end
    axi_rd(8'h3c, d, r);
    chk("unmapped data", 32'h0, d);
    chk("unmapped resp", 32'(ssfc_pkg::RESP_SLVERR), 32'(r));
    axi_wr(8'h40, 16'h1234, r);
    chk("unmapped write", 32'(ssfc_pkg::RESP_SLVERR), 32'(r));
  endtask
  task automatic t_clamp;
    logic [7:0] a;
    logic [1:0] r;
    for (int i = 0; i < ssfc_pkg::NPARAM; i++) begin
      a = 8'(ssfc_pkg::OFF_PARAM0 + 4 * i);
      axi_wr(a, 16'h0000, r);
      rd_chk(a, 32'(ssfc_pkg::PMIN[i]), "low clamp");
      axi_wr(a, 16'hffff, r);
      rd_chk(a, 32'(ssfc_pkg::PMAX[i]), "high clamp");
      axi_wr(a, ssfc_pkg::PDEF[i], r);
    end
  endtask
  task automatic t_modes;
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(ssfc_pkg::OFF_COUNT, 16'h0001, r);
    axi_wr(ssfc_pkg::OFF_COUNT, 16'h0003, r);
    rd_chk(ssfc_pkg::OFF_COUNT, 32'h1, "count above two");
    axi_wr(ssfc_pkg::OFF_TYPE, 16'hffff, r);
    rd_chk(ssfc_pkg::OFF_TYPE, 32'h8303, "type mask");
    for (int i = 0; i < 9; i++) begin
      stage1_bypass <= MODES[i][4];
      axi_wr(ssfc_pkg::OFF_COUNT, {14'h0, MODES[i][25:24]}, r);
      axi_wr(ssfc_pkg::OFF_TYPE, MODES[i][23:8], r);
      axi_rd(ssfc_pkg::OFF_STATUS, d, r);
      chk("stage modes", 32'(MODES[i][3:0]), 32'(d[3:0]));
    end
  endtask
  task automatic t_stream;
    int n;
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(ssfc_pkg::OFF_COUNT, 16'h0000, r);
    stage1_bypass <= 1'b0;
    stall <= 1'b1;
    send(8'd20);
    n = 0;
    while (sp_in_ready !== 1'b0 && n < 100) begin
      @(posedge aclk);
      n++;
    end
    if (n == 100) hang("source refused");
    axi_rd(ssfc_pkg::OFF_STATUS, d, r);
    chk("fifo level full", 32'd16, 32'(d[12:8]));
    chk("held at sink", 32'd0, 32'(src_sink.rx_q.size()));
    stall <= 1'b0;
    drain(20);
    axi_rd(ssfc_pkg::OFF_STATUS, d, r);
    chk("fifo level empty", 32'd0, 32'(d[12:8]));
    axi_wr(ssfc_pkg::OFF_COUNT, 16'h0001, r);
    // Slow stage one, so a bypass that fails shows in the samples
    axi_wr(8'(ssfc_pkg::OFF_PARAM0 + 4 * ssfc_pkg::P_S1_TC), 16'h1388, r);
    axi_wr(ssfc_pkg::OFF_TYPE, 16'h0100, r);
    stage1_bypass <= 1'b1;
    send(8'd6);
    drain(6);
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_clamp();
    t_modes();
    t_stream();
    close_out();
  end
endmodule
